// ===== logic/csiu_cfg.svh
// Constants for the channel status and interrupt unit
// Notes on behaviour
// R1: Processor side takes 8 channel, 4 processor, 1 privileged and 15 memory sources.
// R2: Each source has a mask bit; masked-off sources never reach the processor.
// R3: Source mask register loads from a preferential-area word by instruction.
// R4: Masked sources are sampled only in the first fetch microcycle.
// R5: A status change raises an interrupt and an automatic store, separately.
// R6: Automatic store runs without stalling the processor.
// R7: Status word is three 10-bit fields; every store writes the whole word.
// R8: Status word is stored only on a change or on a status probe.
// R9: Automatic store is held off while a probe is in progress.
// R10: Per-channel store mask, set or removed by data-bus terminal commands.
// R11: Automatic store goes to the controller's change-status location.
// R12: Probe writes status word, sequence pointer, data count to three words.
// R13: Probe freezes changes, stores, clears probed field and latches, releases.
// R14: Probed channel's interrupt trigger is reset before the freeze releases; here both happen at the same clock edge.
// R15: Channel interrupt stays up while status changed since its last probe.
// R16: Interrupts and status stay stacked until serviced; clear per channel.
// R17: Status holds until probed; reading the store area does not clear it.
// R18: Processor-side mask is independent of the controller-side store mask.
// R19: Channel interrupt bits are not latched; they follow their source.
// R20: Asynchronous sources pass two-stage synchronisers before sampling.
// R21: Changes in one cycle merge into a single whole-word store.
`ifndef CSIU_CFG_SVH
`define CSIU_CFG_SVH
`define CSIU_NCHAN 3
`define CSIU_FIELD_W 10
`define CSIU_WORD_W 30
`define CSIU_NSRC 28
`define CSIU_CHAN_SRC_LO 0
`define CSIU_ADDR_W 16
`define CSIU_DATA_W 32
`define CSIU_CHG_OFFSET 16'h0040
`define CSIU_PROBE_OFFSET 16'h0050
`define CSIU_STATUS_RESET 30'h0000_0000
`define CSIU_MASK_RESET 28'h000_0000
`endif

// ===== logic/csiu_pkg.sv
// Types for the channel status and interrupt unit
`include "csiu_cfg.svh"
package csiu_pkg;
  typedef logic [`CSIU_FIELD_W-1:0] csiu_field_t;
  typedef logic [`CSIU_WORD_W-1:0] csiu_word_t;
  typedef logic [`CSIU_NSRC-1:0] csiu_src_t;
  typedef logic [`CSIU_ADDR_W-1:0] csiu_addr_t;
  typedef logic [`CSIU_DATA_W-1:0] csiu_data_t;
  typedef enum logic [2:0] {ST_IDLE, ST_AUTO, ST_P_SW, ST_P_PTR, ST_P_CNT, ST_P_CLR} csiu_state_t;
endpackage

// ===== logic/csiu_sync.sv
// Two-stage synchroniser for a bank of asynchronous source levels
`include "csiu_cfg.svh"
module csiu_sync
  import csiu_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic clkEn, // Freeze when low
  input wire csiu_src_t asyncIn, // Raw source levels
  output csiu_src_t syncOut // Synchronised levels
);
  csiu_src_t meta_q;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= `CSIU_MASK_RESET;
      syncOut <= `CSIU_MASK_RESET;
    end
    else if (clkEn)
    begin
      meta_q <= asyncIn; // R20
      syncOut <= meta_q; // R20
    end
  end
endmodule

// ===== logic/csiu_top.sv
// Channel status and interrupt unit: status word, stores and source interrupts
`include "csiu_cfg.svh"
module csiu_top
  import csiu_pkg::*;
(
  input wire logic clk, // System clock, 125 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic clkEn, // Freezes all state when low
  input wire logic [`CSIU_NCHAN-1:0] chanDelta, // Per-channel status change pulse
  input wire logic [`CSIU_WORD_W-1:0] chanStatusIn, // New status bits per channel
  input wire logic [`CSIU_NCHAN-1:0] maskOnCmd, // Terminal command: store mask on
  input wire logic [`CSIU_NCHAN-1:0] maskOffCmd, // Terminal command: store mask off
  input wire logic [4:0] otherSrc, // Processor and privileged sources
  input wire logic [14:0] memSrc, // Memory sources
  input wire logic [4:0] spareChanSrc, // Channel sources of other units
  input wire logic fetchFirst, // First microcycle of instruction fetch
  input wire logic maskLoad, // Load source mask from preferential word
  input wire csiu_src_t maskWord, // Mask value read from preferential area
  input wire logic probeReq, // Status probe command strobe
  input wire logic [1:0] probeChan, // Channel being probed
  input wire logic [`CSIU_DATA_W-1:0] seqPtrIn, // Probed channel sequence pointer
  input wire logic [`CSIU_DATA_W-1:0] dataCountIn, // Probed channel data count
  input wire logic memReady, // Main store accepts the write
  output csiu_word_t statusWord, // Current channel status word
  output csiu_src_t pendingSrc, // Masked sources sampled at fetch
  output csiu_src_t sourceMask, // Source mask register
  output logic [`CSIU_NCHAN-1:0] chanIrq, // Per-channel interrupt triggers
  output logic [`CSIU_NCHAN-1:0] storeMask, // Per-channel auto store mask
  output logic [`CSIU_NCHAN-1:0] chanLatchClr, // Clear pulse to channel latches
  output logic memWrite, // Write strobe to main store
  output csiu_addr_t memAddr, // Write address
  output csiu_data_t memData, // Write data
  output logic probeBusy, // Probe in progress, changes frozen
  output logic probeDone // One-cycle probe completion
);
  import csiu_pkg::*;

  csiu_state_t state_q;
  csiu_src_t rawSrc;
  csiu_src_t syncSrc;
  csiu_word_t fieldMask;
  logic [`CSIU_NCHAN-1:0] maskedDelta;
  logic anyDelta;
  logic autoPend_q;
  logic [1:0] probeChan_q;
  csiu_data_t seqPtr_q;
  csiu_data_t dataCount_q;
  logic wrLaunch;
  logic wrBusy;
  logic clrFire;

  // Channel triggers go out unlatched into the source vector; other units
  // fill the remaining channel source slots
  assign rawSrc = {memSrc, otherSrc, spareChanSrc, chanIrq}; // R1 R19

  csiu_sync uSync
  (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .asyncIn(rawSrc),
    .syncOut(syncSrc)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `CSIU_NCHAN; gi++)
    begin : gField
      assign fieldMask[gi*`CSIU_FIELD_W +: `CSIU_FIELD_W] =
        {`CSIU_FIELD_W{probeChan_q == 2'(gi)}};
    end
  endgenerate

  // Changes are refused while a probe freezes the inputs
  assign maskedDelta = probeBusy ? 3'h0 : chanDelta; // R13
  assign anyDelta = |(maskedDelta & storeMask); // R10 R21
  assign wrBusy = memWrite && !memReady;
  assign wrLaunch = !wrBusy;
  // The clear waits until the count word is taken, so the freeze never
  // drops while part of the probe record is still unwritten
  assign clrFire = (state_q == ST_P_CLR) && wrLaunch;

  // Source mask register, loaded by instruction from preferential area
  always_ff @(posedge clk)
  begin
    if (reset)
      sourceMask <= `CSIU_MASK_RESET;
    else if (clkEn && maskLoad)
      sourceMask <= maskWord; // R3
  end

  // Sampled only in the first fetch microcycle; held otherwise
  always_ff @(posedge clk)
  begin
    if (reset)
      pendingSrc <= `CSIU_MASK_RESET;
    else if (clkEn && fetchFirst)
      pendingSrc <= syncSrc & sourceMask; // R2 R4 R18
  end

  // Controller-side store mask, independent of the source mask
  always_ff @(posedge clk)
  begin
    if (reset)
      storeMask <= 3'h0;
    else if (clkEn)
      storeMask <= (storeMask | maskOnCmd) & ~maskOffCmd; // R10 R18
  end

  // Status word: each field set only by its channel, cleared only by probe
  always_ff @(posedge clk)
  begin
    if (reset)
      statusWord <= `CSIU_STATUS_RESET;
    else if (clkEn)
    begin
      if (clrFire)
        statusWord <= statusWord & ~fieldMask; // R13 R16 R17
      else
      begin
        for (int i = 0; i < `CSIU_NCHAN; i++)
        begin
          if (maskedDelta[i])
            statusWord[i*`CSIU_FIELD_W +: `CSIU_FIELD_W] <=
              statusWord[i*`CSIU_FIELD_W +: `CSIU_FIELD_W] |
              chanStatusIn[i*`CSIU_FIELD_W +: `CSIU_FIELD_W]; // R7
        end
      end
    end
  end

  // Interrupt triggers: up from a change until its channel is probed
  always_ff @(posedge clk)
  begin
    if (reset)
      chanIrq <= 3'h0;
    else if (clkEn)
    begin
      for (int i = 0; i < `CSIU_NCHAN; i++)
      begin
        if (maskedDelta[i])
          chanIrq[i] <= 1'b1; // R5 R15
        else if (clrFire && probeChan_q == 2'(i))
          chanIrq[i] <= 1'b0; // R14
      end
    end
  end

  // A change met during a busy write is remembered, not lost
  always_ff @(posedge clk)
  begin
    if (reset)
      autoPend_q <= 1'b0;
    else if (clkEn)
    begin
      if (anyDelta)
        autoPend_q <= 1'b1; // R5 R21
      else if (state_q == ST_AUTO && wrLaunch)
        autoPend_q <= 1'b0;
    end
  end

  // Probe capture of the selected channel's pointer and count
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      probeChan_q <= 2'h0;
      seqPtr_q <= 32'h0000_0000;
      dataCount_q <= 32'h0000_0000;
    end
    else if (clkEn && state_q == ST_IDLE && probeReq)
    begin
      probeChan_q <= probeChan;
      seqPtr_q <= seqPtrIn;
      dataCount_q <= dataCountIn;
    end
  end

  // Store sequencer; the probe has priority over a pending auto store
  always_ff @(posedge clk)
  begin
    if (reset)
      state_q <= ST_IDLE;
    else if (clkEn)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (probeReq)
            state_q <= ST_P_SW; // R9
          else if (autoPend_q || anyDelta)
            state_q <= ST_AUTO; // R6 R8
        end
        ST_AUTO:
        begin
          if (wrLaunch)
            state_q <= ST_IDLE;
        end
        ST_P_SW:
        begin
          if (wrLaunch)
            state_q <= ST_P_PTR; // R12
        end
        ST_P_PTR:
        begin
          if (wrLaunch)
            state_q <= ST_P_CNT; // R12
        end
        ST_P_CNT:
        begin
          if (wrLaunch)
            state_q <= ST_P_CLR;
        end
        ST_P_CLR:
        begin
          if (wrLaunch)
            state_q <= ST_IDLE; // R13
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Main store write port; the whole word is always written
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      memWrite <= 1'b0;
      memAddr <= 16'h0000;
      memData <= 32'h0000_0000;
    end
    else if (clkEn && wrLaunch)
    begin
      memWrite <= 1'b0;
      case (state_q)
        ST_AUTO:
        begin
          memWrite <= 1'b1;
          memAddr <= `CSIU_CHG_OFFSET; // R11
          memData <= {2'b00, statusWord}; // R7 R8
        end
        ST_P_SW:
        begin
          memWrite <= 1'b1;
          memAddr <= `CSIU_PROBE_OFFSET; // R12
          memData <= {2'b00, statusWord}; // R7
        end
        ST_P_PTR:
        begin
          memWrite <= 1'b1;
          memAddr <= 16'(`CSIU_PROBE_OFFSET + 16'h0001); // R12
          memData <= seqPtr_q;
        end
        ST_P_CNT:
        begin
          memWrite <= 1'b1;
          memAddr <= 16'(`CSIU_PROBE_OFFSET + 16'h0002); // R12
          memData <= dataCount_q;
        end
        default:
          memWrite <= 1'b0;
      endcase
    end
  end

  // Freeze flag, latch clear and completion; the trigger resets in the
  // clear cycle, at the same edge as the freeze drops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      probeBusy <= 1'b0;
      chanLatchClr <= 3'h0;
      probeDone <= 1'b0;
    end
    else if (clkEn)
    begin
      chanLatchClr <= 3'h0;
      probeDone <= 1'b0;
      if (state_q == ST_IDLE && probeReq)
        probeBusy <= 1'b1; // R9 R13
      else if (clrFire)
      begin
        probeBusy <= 1'b0; // R13 R14
        probeDone <= 1'b1;
        chanLatchClr <= 3'(3'h1 << probeChan_q); // R13
      end
    end
  end
endmodule

// ===== dv/csiu_props.sv
// Concurrent checks on the channel status and interrupt unit ports
module csiu_props (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic clkEn, // Clock enable
  input wire logic [2:0] chanDelta, // Changes
  input wire logic maskLoad, // Mask load
  input wire csiu_pkg::csiu_src_t maskWord, // Mask value
  input wire logic fetchFirst, // Fetch cycle
  input wire logic memReady, // Accept
  input wire csiu_pkg::csiu_word_t statusWord, // Status
  input wire csiu_pkg::csiu_src_t pendingSrc, // Sampled
  input wire csiu_pkg::csiu_src_t sourceMask, // Mask
  input wire logic [2:0] chanIrq, // Irqs
  input wire logic [2:0] storeMask, // Store mask
  input wire logic [2:0] chanLatchClr, // Clear
  input wire logic memWrite, // Strobe
  input wire csiu_pkg::csiu_addr_t memAddr, // Address
  input wire csiu_pkg::csiu_data_t memData, // Data
  input wire logic probeBusy, // Busy
  input wire logic probeDone // Done
);
  import csiu_pkg::*;
  default clocking @(posedge clk); endclocking
  // A frozen clock enable holds every state, so checks pause with it
  default disable iff (reset || !clkEn);
  sequence sProbeGo;
    $rose(probeBusy) && !(memWrite && !memReady);
  endsequence
  sequence sWrAcc(a);
    memWrite && memReady && memAddr == a;
  endsequence
  AST_PROBE_FIRST: assert property (sProbeGo |=> memWrite && memAddr == 16'h0050)
    else $error("probe first write wrong");
  AST_PROBE_PTR: assert property (sWrAcc(16'h0050) |=> memWrite && memAddr == 16'h0051)
    else $error("pointer write missing");
  AST_PROBE_CNT: assert property (sWrAcc(16'h0051) |=> memWrite && memAddr == 16'h0052)
    else $error("count write missing");
  AST_PROBE_WORD: assert property (memWrite && memAddr == 16'h0050 |-> memData == {2'h0, statusWord})
    else $error("probe word differs");
  AST_PROBE_END: assert property (probeDone |-> !probeBusy && $past(probeBusy)
    && $onehot(chanLatchClr) && (chanIrq & chanLatchClr) == 3'h0)
    else $error("probe end wrong");
  AST_AUTO_HOLD: assert property (probeBusy && memWrite |-> memAddr != 16'h0040)
    else $error("auto store during probe");
  AST_AUTO_STORE: assert property (|(chanDelta & storeMask) && !probeBusy && !memWrite
    |-> ##[1:4] memWrite && memAddr == 16'h0040)
    else $error("auto store missing");
  AST_IRQ_RAISE: assert property (chanDelta[0] && !probeBusy |-> ##[1:2] chanIrq[0])
    else $error("irq not raised");
  AST_MASK_LOAD: assert property (maskLoad |=> sourceMask == $past(maskWord))
    else $error("mask not loaded");
  AST_FETCH_ONLY: assert property (!fetchFirst |=> $stable(pendingSrc))
    else $error("pending changed off fetch");
endmodule
bind csiu_top csiu_props u_props
(
  .clk(clk),
  .reset(reset),
  .clkEn(clkEn),
  .chanDelta(chanDelta),
  .maskLoad(maskLoad),
  .maskWord(maskWord),
  .fetchFirst(fetchFirst),
  .memReady(memReady),
  .statusWord(statusWord),
  .pendingSrc(pendingSrc),
  .sourceMask(sourceMask),
  .chanIrq(chanIrq),
  .storeMask(storeMask),
  .chanLatchClr(chanLatchClr),
  .memWrite(memWrite),
  .memAddr(memAddr),
  .memData(memData),
  .probeBusy(probeBusy),
  .probeDone(probeDone)
);

// ===== dv/csiu_mem_model.sv
// Main store model: accepts writes after random stalls
module csiu_mem_model (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset
  output logic memReady // Write accepted
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stalls are random but never longer than two cycles in a row
  logic [1:0] stallCnt_q;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      memReady <= 1'b0;
      stallCnt_q <= 2'h0;
    end
    else if (stallCnt_q == 2'h2 || $urandom_range(0, 2) != 0)
    begin
      memReady <= 1'b1;
      stallCnt_q <= 2'h0;
    end
    else
    begin
      memReady <= 1'b0;
      stallCnt_q <= stallCnt_q + 2'h1;
    end
  end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the channel status and interrupt unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import csiu_pkg::*;
  logic clk = 0, reset = 1, clkEn = 1, fetchFirst = 0, maskLoad = 0, probeReq = 0;
  logic memReady, memWrite, probeBusy, probeDone;
  logic [2:0] chanDelta = 0, maskOnCmd = 0, maskOffCmd = 0, chanIrq, storeMask, chanLatchClr;
  logic [2:0] irq = 0;
  logic [4:0] otherSrc = 0, spareChanSrc = 0;
  logic [14:0] memSrc = 0;
  logic [1:0] probeChan = 0;
  logic [31:0] seqPtrIn = 0, dataCountIn = 0;
  csiu_word_t chanStatusIn = 0, statusWord, word = 0;
  csiu_src_t maskWord = 0, pendingSrc, sourceMask;
  csiu_addr_t memAddr;
  csiu_data_t memData;
  logic [47:0] expQ[$];
  int nErrors = 0, samplesChecked = 0;
  csiu_top DUT
  (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .chanDelta(chanDelta),
    .chanStatusIn(chanStatusIn),
    .maskOnCmd(maskOnCmd),
    .maskOffCmd(maskOffCmd),
    .otherSrc(otherSrc),
    .memSrc(memSrc),
    .spareChanSrc(spareChanSrc),
    .fetchFirst(fetchFirst),
    .maskLoad(maskLoad),
    .maskWord(maskWord),
    .probeReq(probeReq),
    .probeChan(probeChan),
    .seqPtrIn(seqPtrIn),
    .dataCountIn(dataCountIn),
    .memReady(memReady),
    .statusWord(statusWord),
    .pendingSrc(pendingSrc),
    .sourceMask(sourceMask),
    .chanIrq(chanIrq),
    .storeMask(storeMask),
    .chanLatchClr(chanLatchClr),
    .memWrite(memWrite),
    .memAddr(memAddr),
    .memData(memData),
    .probeBusy(probeBusy),
    .probeDone(probeDone)
  );
  csiu_mem_model u_mem
  (
    .clk(clk),
    .reset(reset),
    .memReady(memReady)
  );
  initial forever #4 clk = ~clk;
  task automatic cmp(logic [47:0] got, logic [47:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic printVerdict();
    $display("checks=%0d errors=%0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(negedge clk);
  endtask
  // Stores are compared as they are accepted, so stalls never shift results
  always @(posedge clk)
    if (!reset && memWrite === 1'b1 && memReady === 1'b1)
    begin
      if (expQ.size() == 0)
        cmp({memAddr, memData}, '0);
      else
        cmp({memAddr, memData}, expQ.pop_front());
    end
  task automatic delta(logic [2:0] d, bit store);
    chanStatusIn = $urandom();
    chanDelta = d;
    for (int i = 0; i < 3; i++)
      if (d[i])
        word[10*i +: 10] |= chanStatusIn[10*i +: 10];
    irq |= d;
    if (store)
      expQ.push_back({16'h0040, 2'h0, word});
    tick();
    chanDelta = 0;
    tick(8);
  endtask
  task automatic probe(logic [1:0] ch);
    repeat (20) if (memWrite === 1'b1) tick();
    seqPtrIn = $urandom();
    dataCountIn = $urandom();
    probeChan = ch;
    probeReq = 1;
    expQ.push_back({16'h0050, 2'h0, word});
    expQ.push_back({16'h0051, seqPtrIn});
    expQ.push_back({16'h0052, dataCountIn});
    tick();
    probeReq = 0;
    tick();
    // Changes while frozen are lost, so they must not reach the word
    chanStatusIn = '1;
    chanDelta = 3'h7;
    tick();
    chanDelta = 0;
    repeat (40)
    begin
      if (probeDone === 1'b1)
        break;
      tick();
    end
    word[10*ch +: 10] = '0;
    irq[ch] = 1'b0;
    cmp(chanLatchClr, 3'h1 << ch);
    cmp({chanIrq, statusWord}, {irq, word});
  endtask
  initial
  begin
    void'($urandom(24));
    repeat (10) @(posedge clk);
    tick();
    reset = 0;
    maskOnCmd = 3'h7;
    tick();
    maskOnCmd = 0;
    tick();
    cmp(storeMask, 3'h7);
    delta(3'h2, 1);
    delta(3'h5, 1);
    maskOnCmd = 3'h4;
    maskOffCmd = 3'h4;
    tick();
    maskOnCmd = 0;
    maskOffCmd = 0;
    tick();
    cmp(storeMask, 3'h3);
    delta(3'h4, 0);
    cmp({chanIrq, statusWord}, {irq, word});
    for (int c = 0; c < 3; c++)
      probe(c);
    delta(3'h3, 1);
    // A low clock enable must swallow a change that would otherwise store
    clkEn = 0;
    chanStatusIn = '1;
    chanDelta = 3'h3;
    tick(2);
    chanDelta = 0;
    clkEn = 1;
    tick(4);
    cmp({chanIrq, statusWord}, {irq, word});
    for (int k = 0; k < 4; k++)
    begin
      logic [27:0] e;
      maskWord = $urandom();
      maskLoad = 1;
      {memSrc, otherSrc, spareChanSrc} = $urandom();
      tick();
      maskLoad = 0;
      tick(3);
      fetchFirst = 1;
      tick();
      fetchFirst = 0;
      tick(2);
      e = {memSrc, otherSrc, spareChanSrc, irq} & maskWord;
      cmp(pendingSrc, e);
      {memSrc, otherSrc, spareChanSrc} = ~{memSrc, otherSrc, spareChanSrc};
      tick(4);
      cmp(pendingSrc, e);
    end
    cmp(expQ.size(), 0);
    printVerdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    nErrors++;
    printVerdict();
  end
endmodule
